// [psp_sram_port.sv]
// pipelined burst sram port: control pipeline, data pins and storage
`timescale 1ns/10ps
module psp_sram_port #(
  parameter int MEM_AW     = 6,
  parameter int FIFO_DEPTH = psp_pkg::FIFO_DEPTH
) (
  input  wire logic                        REF_CLK_IN,
  input  wire logic                        SRST_IN,
  input  wire logic [psp_pkg::ADDR_W-1:0]  ADDR_IN,
  input  wire logic                        CHIP_SELECT_LOW_A_N_IN,
  input  wire logic                        CHIP_SELECT_HIGH_IN,
  input  wire logic                        CHIP_SELECT_LOW_B_N_IN,
  input  wire logic                        WRITE_SELECT_N_IN,
  input  wire logic [psp_pkg::LANES-1:0]   BYTE_LANE_WRITE_N_IN,
  input  wire logic                        ADVANCE_OR_LOAD_IN,
  input  wire logic                        CLOCK_QUALIFY_N_IN,
  input  wire logic                        OUTPUT_DRIVE_N_IN,
  input  wire logic                        BURST_ORDER_IN,
  input  wire logic [psp_pkg::DATA_W-1:0]  DATA_IN,
  input  wire logic [psp_pkg::LANES-1:0]   PARITY_LINES_IN,
  output logic      [psp_pkg::DATA_W-1:0]  DATA_OUT,
  output logic                             DATA_OE_N_OUT,
  output logic      [psp_pkg::LANES-1:0]   PARITY_LINES_OUT,
  output logic                             PARITY_LINES_OE_N_OUT
);
  localparam int WR_W = $bits(psp_pkg::psp_wr_t);
  localparam int MEM_DEPTH = 1 << MEM_AW;
  initial begin
    if (MEM_AW < psp_pkg::BURST_W || MEM_AW > psp_pkg::ADDR_W) $error("bad MEM_AW");
  end
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  psp_pkg::psp_pins_t raw;
  psp_pkg::psp_pins_t sync_a;
  psp_pkg::psp_pins_t p;
  assign raw = '{addr: ADDR_IN, cs_a_n: CHIP_SELECT_LOW_A_N_IN, cs_h: CHIP_SELECT_HIGH_IN,
                 cs_b_n: CHIP_SELECT_LOW_B_N_IN, we_n: WRITE_SELECT_N_IN,
                 bw_n: BYTE_LANE_WRITE_N_IN, adv: ADVANCE_OR_LOAD_IN,
                 cq_n: CLOCK_QUALIFY_N_IN, oe_n: OUTPUT_DRIVE_N_IN, mode: BURST_ORDER_IN,
                 dq: DATA_IN, dp: PARITY_LINES_IN};
  // every pin shifts by the same two cycles, so relative timing holds
  always_ff @(posedge REF_CLK_IN) begin
    sync_a <= raw;
    p      <= sync_a;
  end
  // ----------------------------------------
  // decode
  // ----------------------------------------
  psp_pkg::psp_cmd_t s1;
  psp_pkg::psp_cmd_t s2;
  psp_pkg::psp_cmd_t next_s1;
  logic                          mode;
  logic                          rd_active;
  logic                          fifo_in_ready;
  logic                          fifo_out_valid;
  psp_pkg::psp_wr_t              fifo_out;
  psp_pkg::psp_wr_t              wr_entry;
  logic [psp_pkg::BURST_W-1:0]   lo;
  logic [psp_pkg::ADDR_W-1:0]    s1_addr;
  logic [psp_pkg::LANES-1:0][psp_pkg::LANE_W-1:0] rdata;
  // a full queue stalls all but the draining; a masked edge stalls the draining too
  wire qual = !p.cq_n && fifo_in_ready;
  wire sel  = !p.cs_a_n && p.cs_h && !p.cs_b_n;
  wire load = !p.adv;
  wire push = qual && s2.op == psp_pkg::OP_WRITE;
  wire next_drive = qual ? (s1.op == psp_pkg::OP_READ) : rd_active;
  assign lo = mode ? (s1.base[psp_pkg::BURST_W-1:0] ^ s1.cnt)
                   : (s1.base[psp_pkg::BURST_W-1:0] + s1.cnt);
  assign s1_addr = {s1.base[psp_pkg::ADDR_W-1:psp_pkg::BURST_W], lo};
  always_comb begin
    next_s1      = s1;
    next_s1.bw_n = p.bw_n;
    if (load) begin
      next_s1.base = p.addr;
      next_s1.cnt  = psp_pkg::RST_CNT;
      if (!sel) next_s1.op = psp_pkg::OP_IDLE;
      else if (p.we_n) next_s1.op = psp_pkg::OP_READ;
      else next_s1.op = psp_pkg::OP_WRITE;
    end else begin
      next_s1.cnt = s1.cnt + 1'b1;
    end
  end
  // ----------------------------------------
  // pipeline
  // ----------------------------------------
  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      s1        <= '{op: psp_pkg::OP_IDLE, default: '0};
      s2        <= '{op: psp_pkg::OP_IDLE, default: '0};
      rd_active <= 1'b0;
      mode      <= p.mode;
    end else if (qual) begin
      s1        <= next_s1;
      s2        <= '{op: s1.op, base: s1_addr, cnt: s1.cnt, bw_n: s1.bw_n};
      rd_active <= s1.op == psp_pkg::OP_READ;
    end
  end
  // ----------------------------------------
  // data pins
  // ----------------------------------------
  // idle or write in the output stage never drives, whatever the enable
  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      DATA_OE_N_OUT         <= psp_pkg::RST_OE_N;
      PARITY_LINES_OE_N_OUT <= psp_pkg::RST_OE_N;
      DATA_OUT              <= '0;
      PARITY_LINES_OUT      <= '0;
    end else begin
      DATA_OE_N_OUT         <= !(next_drive && !p.oe_n);
      PARITY_LINES_OE_N_OUT <= !(next_drive && !p.oe_n);
      if (qual && s1.op == psp_pkg::OP_READ) begin
        DATA_OUT         <= {rdata[1][7:0], rdata[0][7:0]};
        PARITY_LINES_OUT <= {rdata[1][8], rdata[0][8]};
      end
    end
  end
  // ----------------------------------------
  // write queue and storage
  // ----------------------------------------
  assign wr_entry = '{addr: s2.base, bw_n: s2.bw_n,
                      data: {{p.dp[1], p.dq[15:8]}, {p.dp[0], p.dq[7:0]}}};
  psp_fifo #(.W(WR_W), .DEPTH(FIFO_DEPTH)) u_wr_fifo (
    .clk_in        (REF_CLK_IN),
    .srst_in       (SRST_IN),
    .in_valid_in   (push),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (wr_entry),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (!p.cq_n),
    .out_data_out  (fifo_out)
  );
  // draining also halts on a masked edge, as pushing does, so the queue never holds more than one entry
  wire drain = fifo_out_valid && !p.cq_n;
  for (genvar g = 0; g < psp_pkg::LANES; g++) begin : g_lane
    logic [psp_pkg::LANE_W-1:0] mem [MEM_DEPTH];
    assign rdata[g] = mem[s1_addr[MEM_AW-1:0]];
    always_ff @(posedge REF_CLK_IN) begin
      if (drain && !fifo_out.bw_n[g]) begin
        mem[fifo_out.addr[MEM_AW-1:0]] <= fifo_out.data[g];
      end
    end
  end
  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (SRST_IN);
  property p_sel;
    qual && load && sel && p.we_n |=> s1.op == psp_pkg::OP_READ;
  endproperty
  a_sel: assert property (p_sel) else $error("selected load did not start a read");
  property p_desel;
    qual && load && !sel |=> (s1.op == psp_pkg::OP_IDLE) and (qual |=> DATA_OE_N_OUT);
  endproperty
  a_desel: assert property (p_desel) else $error("deselect still drives");
  property p_oe_high;
    p.oe_n |=> DATA_OE_N_OUT && PARITY_LINES_OE_N_OUT;
  endproperty
  a_oe_high: assert property (p_oe_high) else $error("pins drive with enable high");
  property p_wr_float;
    s2.op == psp_pkg::OP_WRITE |-> DATA_OE_N_OUT;
  endproperty
  a_wr_float: assert property (p_wr_float) else $error("drive in write data cycle");
  property p_freeze;
    !qual |=> $stable(s1) && $stable(s2) && $stable(DATA_OUT);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved on masked edge");
  property p_read;
    qual && s1.op == psp_pkg::OP_READ && !p.oe_n |=> !DATA_OE_N_OUT;
  endproperty
  a_read: assert property (p_read) else $error("read not driven");
  property p_wr_take;
    qual && load && sel && !p.we_n |=>
      s1.op == psp_pkg::OP_WRITE && s1.base == $past(p.addr);
  endproperty
  a_wr_take: assert property (p_wr_take) else $error("selected load did not start a write");
  property p_adv;
    qual && !load |=> s1.cnt == $past(s1.cnt) + 2'h1 && s1.op == $past(s1.op);
  endproperty
  a_adv: assert property (p_adv) else $error("burst counter did not advance");
  property p_par;
    DATA_OE_N_OUT == PARITY_LINES_OE_N_OUT;
  endproperty
  a_par: assert property (p_par) else $error("parity direction differs from data");
  property p_mode;
    ##1 $stable(mode);
  endproperty
  a_mode: assert property (p_mode) else $error("burst order changed in operation");
  property p_wr2;
    qual && s1.op == psp_pkg::OP_WRITE |=> (s2.op == psp_pkg::OP_WRITE) and
      (qual |-> push && wr_entry.addr == $past(s1_addr));
  endproperty
  a_wr2: assert property (p_wr2) else $error("write data not taken");
  // read data must stand until the next read leaves the pipeline
  property p_out_hold;
    !(qual && s1.op == psp_pkg::OP_READ) |=> $stable(DATA_OUT) && $stable(PARITY_LINES_OUT);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("read data changed without a read");
  property p_idle_float;
    qual && s1.op == psp_pkg::OP_IDLE |=> DATA_OE_N_OUT && PARITY_LINES_OE_N_OUT;
  endproperty
  a_idle_float: assert property (p_idle_float) else $error("idle stage drives pins");
  // a stretch must keep a running read on the pins, not deselect it
  property p_stretch;
    !qual && rd_active && !p.oe_n |=> !DATA_OE_N_OUT;
  endproperty
  a_stretch: assert property (p_stretch) else $error("stretch dropped the read drive");
  property p_load_cnt;
    qual && load |=> s1.cnt == psp_pkg::RST_CNT;
  endproperty
  a_load_cnt: assert property (p_load_cnt) else $error("load did not restart burst");
endmodule

// [psp_pkg.sv]
// shared types and constants of the pipelined sram port
package psp_pkg;
  // ----------------------------------------
  // widths and counts
  // ----------------------------------------
  localparam int ADDR_W        = 18;
  localparam int DATA_W        = 16;
  localparam int LANES         = 2;
  localparam int LANE_W        = 9;
  localparam int BURST_W       = 2;
  localparam int FIFO_DEPTH    = 32;
  localparam int CLK_PERIOD_NS = 20;
  localparam int SYNC_STAGES   = 2;
  // ----------------------------------------
  // values after reset, save RST_MODE: reset takes mode from the burst order pin
  // ----------------------------------------
  localparam logic             RST_OE_N  = 1'h1;
  localparam logic             RST_MODE  = 1'h1;
  localparam logic [BURST_W-1:0] RST_CNT = 2'h0;

  typedef enum logic [1:0] {OP_IDLE, OP_READ, OP_WRITE} psp_op_t;

  // sampled pin group
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              cs_a_n;
    logic              cs_h;
    logic              cs_b_n;
    logic              we_n;
    logic [LANES-1:0]  bw_n;
    logic              adv;
    logic              cq_n;
    logic              oe_n;
    logic              mode;
    logic [DATA_W-1:0] dq;
    logic [LANES-1:0]  dp;
  } psp_pins_t;

  // pipeline stage command
  typedef struct packed {
    psp_op_t           op;
    logic [ADDR_W-1:0] base;
    logic [BURST_W-1:0] cnt;
    logic [LANES-1:0]  bw_n;
  } psp_cmd_t;

  // queued write
  typedef struct packed {
    logic [ADDR_W-1:0]             addr;
    logic [LANES-1:0]              bw_n;
    logic [LANES-1:0][LANE_W-1:0]  data;
  } psp_wr_t;
endpackage

// [psp_fifo.sv]
// flip-flop fifo with valid and ready on both sides
`timescale 1ns/10ps
module psp_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = psp_pkg::FIFO_DEPTH
) (
  input  wire logic         clk_in,
  input  wire logic         srst_in,
  input  wire logic         in_valid_in,
  output logic              in_ready_out,
  input  wire logic [W-1:0] in_data_in,
  output logic              out_valid_out,
  input  wire logic         out_ready_in,
  output logic [W-1:0]      out_data_out
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("fifo depth must be a power of two");
  end
  logic [W-1:0] store [DEPTH];
  logic [AW:0]  wptr;
  logic [AW:0]  rptr;
  wire          push = in_valid_in && in_ready_out;
  wire          pop  = out_valid_out && out_ready_in;
  assign in_ready_out  = (wptr - rptr) != (AW+1)'(DEPTH);
  assign out_valid_out = wptr != rptr;
  assign out_data_out  = store[rptr[AW-1:0]];
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      wptr <= '0;
      rptr <= '0;
    end else begin
      if (push) wptr <= wptr + 1'b1;
      if (pop) rptr <= rptr + 1'b1;
    end
  end
  always_ff @(posedge clk_in) begin
    if (push) store[wptr[AW-1:0]] <= in_data_in;
  end
endmodule

// [psp_ctl_model.sv]
// memory controller model driving the pins of the sram port
`timescale 1ns/10ps
module psp_ctl_model (
  input  wire logic                        clk_in,
  output logic      [psp_pkg::ADDR_W-1:0]  addr_out,
  output logic      [2:0]                  cs_out,
  output logic                             we_n_out,
  output logic      [1:0]                  bw_n_out,
  output logic                             adv_out,
  output logic                             cq_n_out,
  output logic      [17:0]                 wd_out,
  output logic                             wd_en_out
);
  // ----------------------------------------
  // write data pipeline
  // ----------------------------------------
  logic        s0v = 1'b0;
  logic        s1v = 1'b0;
  logic [17:0] s0d = 18'h0;
  logic [17:0] s1d = 18'h0;
  initial begin
    addr_out  = '0;
    cs_out    = 3'h7;
    we_n_out  = 1'b1;
    bw_n_out  = 2'h3;
    adv_out   = 1'b0;
    cq_n_out  = 1'b0;
    wd_out    = 18'h0;
    wd_en_out = 1'b0;
  end
  // one call is one clock; cs is {low_a_n, high, low_b_n}
  task automatic cmd(input logic [17:0] a, input logic [2:0] cs, input logic we_n,
                     input logic [1:0] bw, input logic adv, input logic cq_n,
                     input logic [17:0] wd);
    @(posedge clk_in);
    addr_out  <= a;
    cs_out    <= cs;
    we_n_out  <= we_n;
    bw_n_out  <= bw;
    adv_out   <= adv;
    cq_n_out  <= cq_n;
    wd_en_out <= s1v;
    // released lines flip so a stale value never looks valid
    wd_out    <= s1v ? s1d : ~wd_out;
    if (!cq_n) begin
      s1v = s0v;
      s1d = s0d;
      s0v = (cs == 3'h2) && !adv && !we_n;
      s0d = wd;
    end
  endtask
endmodule

// [tb_pipelined_sram_port_control.sv]
// self-checking bench of the pipelined sram port
`timescale 1ns/10ps
module tb_pipelined_sram_port_control;
  // ----------------------------------------
  // pins, model and counters
  // ----------------------------------------
  logic        clk  = 1'b0;
  logic        srst = 1'b1;
  logic        drv_n = 1'b0;
  logic        mode = 1'b1;
  logic [17:0] addr, wd;
  logic [17:0] mem [0:15];
  logic [2:0]  cs;
  logic [1:0]  bw, pout, rb;
  logic        we_n, adv, cq_n, wd_en, oe_n, poe_n;
  logic [15:0] dout;
  logic [3:0]  ra;
  int          failures = 0;
  int          tests_run = 0;
  int          cyc = 0;
  always #10 clk = ~clk;
  psp_ctl_model ctl_u (.clk_in(clk), .addr_out(addr), .cs_out(cs), .we_n_out(we_n),
    .bw_n_out(bw), .adv_out(adv), .cq_n_out(cq_n), .wd_out(wd), .wd_en_out(wd_en));
  psp_sram_port #(.MEM_AW(4)) dut_u (.REF_CLK_IN(clk), .SRST_IN(srst), .ADDR_IN(addr),
    .CHIP_SELECT_LOW_A_N_IN(cs[2]), .CHIP_SELECT_HIGH_IN(cs[1]),
    .CHIP_SELECT_LOW_B_N_IN(cs[0]), .WRITE_SELECT_N_IN(we_n), .BYTE_LANE_WRITE_N_IN(bw),
    .ADVANCE_OR_LOAD_IN(adv), .CLOCK_QUALIFY_N_IN(cq_n), .OUTPUT_DRIVE_N_IN(drv_n),
    .BURST_ORDER_IN(mode), .DATA_IN(oe_n ? wd[15:0] : dout),
    .PARITY_LINES_IN(poe_n ? wd[17:16] : pout), .DATA_OUT(dout), .DATA_OE_N_OUT(oe_n),
    .PARITY_LINES_OUT(pout), .PARITY_LINES_OE_N_OUT(poe_n));
  // ----------------------------------------
  // expectations and checks
  // ----------------------------------------
  function automatic logic [17:0] merge(logic [17:0] o, logic [17:0] n, logic [1:0] b);
    merge = o;
    if (!b[0]) begin
      merge[7:0] = n[7:0];
      merge[16]  = n[16];
    end
    if (!b[1]) begin
      merge[15:8] = n[15:8];
      merge[17]   = n[17];
    end
  endfunction
  function automatic logic [3:0] baddr(logic [3:0] a, logic [1:0] k);
    baddr = {a[3:2], mode ? a[1:0] ^ k : a[1:0] + k};
  endfunction
  task automatic chk(logic [17:0] got, logic [17:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: data %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkb(logic got, logic exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic idle();
    ctl_u.cmd(18'($urandom), 3'h7, 1'b1, 2'h3, 1'b0, 1'b0, 18'h0);
  endtask
  task automatic wr(logic [3:0] a, logic [1:0] b, logic [17:0] d);
    mem[a] = merge(mem[a], d, b);
    ctl_u.cmd({14'h0, a}, 3'h2, 1'b0, b, 1'b0, 1'b0, d);
    idle();
    idle();
  endtask
  // hold cycles keep qualify high right after the load
  task automatic rd(logic [3:0] a, int n, int hold);
    int w;
    ctl_u.cmd({14'h0, a}, 3'h2, 1'b1, 2'h3, 1'b0, 1'b0, 18'h0);
    repeat (hold) ctl_u.cmd(18'h0, 3'h7, 1'b1, 2'h3, 1'b0, 1'b1, 18'h0);
    for (int k = 1; k < n; k++) ctl_u.cmd(18'h0, 3'h7, 1'b1, 2'h3, 1'b1, 1'b0, 18'h0);
    #1;
    w = 0;
    while (oe_n !== 1'b0 && w < 12) begin
      idle();
      #1;
      w++;
    end
    for (int k = 0; k < n; k++) begin
      chkb(oe_n, 1'b0);
      chkb(poe_n, oe_n);
      chk({pout, dout}, mem[baddr(a, 2'(k))]);
      idle();
      #1;
    end
  endtask
  task automatic rd_none(logic [3:0] a, logic [2:0] c);
    ctl_u.cmd({14'h0, a}, c, 1'b1, 2'h3, 1'b0, 1'b0, 18'h0);
    repeat (8) begin
      idle();
      #1;
      chkb(oe_n, 1'b1);
    end
  endtask
  task automatic rst(logic m);
    @(posedge clk);
    srst <= 1'b1;
    mode <= m;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
  endtask
  task automatic summarize();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ----------------------------------------
  // monitors and sequence
  // ----------------------------------------
  always @(negedge clk) begin
    if (wd_en) chkb(oe_n, 1'b1);
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      $display("mismatch at %0t: run too long", $time);
      summarize();
    end
  end
  initial begin
    void'($urandom(52198));
    rst(1'b1);
    for (int i = 0; i < 16; i++) wr(4'(i), 2'h0, 18'($urandom));
    for (int i = 0; i < 14; i++) begin
      ra = 4'($urandom);
      rb = 2'($urandom);
      wr(ra, rb, 18'($urandom));
      rd(ra, 1, 0);
    end
    wr(4'h5, 2'h3, 18'h3FFFF);
    rd(4'h5, 1, 0);
    ctl_u.cmd(18'h5, 3'h2, 1'b0, 2'h0, 1'b0, 1'b1, 18'h0);
    idle();
    idle();
    rd(4'h5, 1, 0);
    rd(4'h9, 1, 5);
    rd_none(4'h3, 3'h6);
    rd_none(4'h3, 3'h0);
    rd_none(4'h3, 3'h3);
    @(posedge clk);
    drv_n <= 1'b1;
    rd_none(4'h2, 3'h2);
    @(posedge clk);
    drv_n <= 1'b0;
    rd(4'h1, 4, 0);
    rd(4'h6, 4, 0);
    rst(1'b0);
    rd(4'h1, 4, 0);
    rd(4'hE, 4, 0);
    summarize();
  end
endmodule
